//--- inc/apmc_pkg.sv
package apmc_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 5;
    // Full-rate sample period at 2 MSPS
    localparam int SAMPLE_PERIOD_NS = 500;

    // Analog phase times
    localparam int CONV_TIME_NS = 300;
    localparam int NAP_WAKE_TIME_NS = 200;
    localparam int PWRUP_TIME_NS = 1000;

    // Least times, rounded up to whole core cycles
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NAP_WAKE_CYCLES =
        (NAP_WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_CYCLES =
        (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Phase counter width
    localparam int CNT_W = 16;

    // Register write port layout
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam logic [7:0] ADDR_UNLOCK = 8'h11;
    localparam logic [7:0] DATA_UNLOCK = 8'h69;
    localparam logic [7:0] ADDR_PDC = 8'h04;
    localparam logic [7:0] PDC_RESET = 8'h00;
    localparam int PDC_NAP_EN_BIT = 0;
    localparam int PDC_DEEP_BIT = 1;

    // Pin synchroniser slots
    localparam int SYNC_CST = 0;
    localparam int SYNC_CS = 1;
    localparam int SYNC_W = 2;

    // Power-mode sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONV,
        ST_NAP,
        ST_WAKE,
        ST_DEEP,
        ST_PWRUP
    } apmc_state_t;

endpackage

//--- verilog/apmc_sync.sv
`timescale 1ns/1ps
module apmc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

//--- verilog/apmc_power_ctrl.sv
`timescale 1ns/1ps
// Contract
// R1 - Normal mode keeps everything powered between conversions
// R2 - Light sleep only while its enable bit set; the bit is checked at entry only, clearing it does not end light sleep
// R3 - Start high after conversion: light sleep, held
// R4 - Start falling edge ends light sleep, wakes
// R5 - Host waits wake time before next start
// R6 - Cycle is conversion plus sleep plus wake
// R7 - Unlock value at unlock address gates changes
// R8 - Deep sleep entered on chip-select rising edge
// R9 - Deep sleep: analog off, interface and registers kept
// R10 - Ready held high during deep sleep
// R11 - Clearing request starts power-up, ready high
// R12 - Host waits power-up time before converting
// R13 - Enable clear: no light sleep at conversion end
module apmc_power_ctrl #(
    parameter int CONV_CYC = apmc_pkg::CONV_CYCLES,
    parameter int NAP_WAKE_CYC = apmc_pkg::NAP_WAKE_CYCLES,
    parameter int PWRUP_CYC = apmc_pkg::PWRUP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic conversion_start,
    input wire logic chip_select_n,
    input wire logic reg_wr_valid,
    input wire logic [apmc_pkg::REG_ADDR_W-1:0] reg_wr_addr,
    input wire logic [apmc_pkg::REG_DATA_W-1:0] reg_wr_data,
    output logic ready_output,
    output logic converting,
    output logic nap_power_down,
    output logic deep_sleep_mode,
    output logic [apmc_pkg::REG_DATA_W-1:0] power_down_control
);

    localparam int CONV_LAST = CONV_CYC - 1;

    typedef struct packed {
        apmc_pkg::apmc_state_t state;
        logic [apmc_pkg::CNT_W-1:0] cnt;
        logic [apmc_pkg::REG_DATA_W-1:0] pdc;
        logic unlocked;
        logic deep_pend;
        logic cst_prev;
        logic cs_prev;
        logic ready;
        logic conv;
        logic nap_off;
        logic deep_off;
    } apmc_ctl_t;

    apmc_ctl_t s_r;
    apmc_ctl_t s_nxt;
    logic [apmc_pkg::SYNC_W-1:0] pins_raw;
    logic [apmc_pkg::SYNC_W-1:0] pins_sync;
    logic cst;
    logic cs_n;
    logic cs_rise;
    logic nap_en;
    logic deep_req;
    logic take_deep;

    // Pins from the host are asynchronous to the core clock
    assign pins_raw[apmc_pkg::SYNC_CST] = conversion_start;
    // Select travels active high so the reset level matches the idle pin
    assign pins_raw[apmc_pkg::SYNC_CS] = ~chip_select_n;

    apmc_sync #(
        .WIDTH(apmc_pkg::SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .d(pins_raw),
        .q(pins_sync)
    );

    // Synchronised levels and edges
    assign cst = pins_sync[apmc_pkg::SYNC_CST];
    assign cs_n = ~pins_sync[apmc_pkg::SYNC_CS];
    assign cs_rise = cs_n & ~s_r.cs_prev;
    assign nap_en = s_r.pdc[apmc_pkg::PDC_NAP_EN_BIT]; // R2
    assign deep_req = s_r.pdc[apmc_pkg::PDC_DEEP_BIT];

    // Next-state logic for the whole sequencer
    always_comb begin
        s_nxt = s_r;
        take_deep = 1'b0;
        s_nxt.cst_prev = cst;
        s_nxt.cs_prev = cs_n;
        if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end

        // Register writes; the unlock is spent by the next control write
        if (reg_wr_valid) begin
            if (reg_wr_addr == apmc_pkg::ADDR_UNLOCK &&
                reg_wr_data == apmc_pkg::DATA_UNLOCK) begin
                s_nxt.unlocked = 1'b1; // R7
            end else if (reg_wr_addr == apmc_pkg::ADDR_PDC &&
                s_r.unlocked) begin
                s_nxt.pdc = reg_wr_data; // R7
                s_nxt.unlocked = 1'b0;
            end
        end

        unique case (s_r.state)
            // Normal acquisition, all blocks powered
            apmc_pkg::ST_IDLE: begin
                if (s_r.deep_pend) begin
                    take_deep = 1'b1;
                    s_nxt.state = apmc_pkg::ST_DEEP; // R8
                end else if (cst && !s_r.cst_prev) begin
                    s_nxt.state = apmc_pkg::ST_CONV;
                    s_nxt.cnt = apmc_pkg::CNT_W'(CONV_CYC - 1); // R6
                end
            end
            // Fixed-length conversion
            apmc_pkg::ST_CONV: begin
                if (s_r.cnt == '0) begin
                    if (nap_en && cst) begin
                        s_nxt.state = apmc_pkg::ST_NAP; // R3
                    end else begin
                        s_nxt.state = apmc_pkg::ST_IDLE; // R13
                    end
                end
            end
            // Light sleep lasts while the start pin stays high
            apmc_pkg::ST_NAP: begin
                if (s_r.deep_pend) begin
                    take_deep = 1'b1;
                    s_nxt.state = apmc_pkg::ST_DEEP; // R8
                end else if (!cst) begin
                    s_nxt.state = apmc_pkg::ST_WAKE; // R4
                    s_nxt.cnt = apmc_pkg::CNT_W'(NAP_WAKE_CYC - 1);
                end
            end
            // Light-sleep wake-up; start edges are ignored here
            apmc_pkg::ST_WAKE: begin
                if (s_r.cnt == '0) begin
                    s_nxt.state = apmc_pkg::ST_IDLE; // R6
                end
            end
            // Deep sleep; register writes stay live above
            apmc_pkg::ST_DEEP: begin
                if (!deep_req) begin
                    s_nxt.state = apmc_pkg::ST_PWRUP; // R11
                    s_nxt.cnt = apmc_pkg::CNT_W'(PWRUP_CYC - 1);
                end
            end
            // Power-up after deep sleep
            apmc_pkg::ST_PWRUP: begin
                if (s_r.cnt == '0) begin
                    s_nxt.state = apmc_pkg::ST_IDLE;
                end
            end
        endcase

        // Deep-sleep request armed by chip-select rise; set wins over clear
        if (!deep_req || take_deep) begin
            s_nxt.deep_pend = 1'b0;
        end
        if (cs_rise && deep_req) begin
            s_nxt.deep_pend = 1'b1; // R8
        end

        // Registered outputs decoded from the next state
        s_nxt.conv = (s_nxt.state == apmc_pkg::ST_CONV);
        s_nxt.nap_off = (s_nxt.state == apmc_pkg::ST_NAP); // R1
        s_nxt.deep_off = (s_nxt.state == apmc_pkg::ST_DEEP); // R9
        s_nxt.ready = (s_nxt.state != apmc_pkg::ST_CONV) &&
            (s_nxt.state != apmc_pkg::ST_WAKE); // R10
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '{state: apmc_pkg::ST_IDLE, cnt: '0,
                pdc: apmc_pkg::PDC_RESET, unlocked: 1'b0,
                deep_pend: 1'b0, cst_prev: 1'b0, cs_prev: 1'b1,
                ready: 1'b1, conv: 1'b0, nap_off: 1'b0, deep_off: 1'b0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign ready_output = s_r.ready;
    assign converting = s_r.conv;
    assign nap_power_down = s_r.nap_off;
    assign deep_sleep_mode = s_r.deep_off;
    assign power_down_control = s_r.pdc;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !ce);

    chk_idle_full_power: assert property ( // R1
        (s_r.state == apmc_pkg::ST_IDLE) |-> !s_r.nap_off && !s_r.deep_off)
        else $error("power down outside a sleep mode");

    chk_nap_needs_enable: assert property ( // R2
        $rose(s_r.nap_off) |-> $past(nap_en))
        else $error("light sleep entered while disabled");

    chk_nap_entry_hold: assert property ( // R3
        (s_r.state == apmc_pkg::ST_CONV && s_r.cnt == '0 && nap_en && cst)
        ##1 (cst && !s_r.deep_pend)[*2] |-> s_r.nap_off)
        else $error("light sleep not entered or not held");

    chk_no_nap_disabled: assert property ( // R13
        (s_r.state == apmc_pkg::ST_CONV && s_r.cnt == '0 && !nap_en)
        |=> s_r.state == apmc_pkg::ST_IDLE && !s_r.nap_off)
        else $error("light sleep entered with enable clear");

    chk_wake_on_fall: assert property ( // R4
        (s_r.nap_off && !cst && !s_r.deep_pend)
        |=> s_r.state == apmc_pkg::ST_WAKE && !s_r.ready)
        else $error("start fall did not begin wake-up");

    chk_conv_length: assert property ( // R6
        $rose(s_r.conv) |-> s_r.conv ##CONV_LAST s_r.conv ##1 !s_r.conv)
        else $error("conversion length wrong");

    chk_unlock_gate: assert property ( // R7
        (reg_wr_valid && reg_wr_addr == apmc_pkg::ADDR_PDC && !s_r.unlocked)
        |=> s_r.pdc == $past(s_r.pdc))
        else $error("control written without unlock");

    chk_deep_entry: assert property ( // R8
        (s_r.deep_pend && s_r.state == apmc_pkg::ST_IDLE) |=> s_r.deep_off)
        else $error("deep sleep not entered");

    chk_deep_iface_live: assert property ( // R9
        (s_r.deep_off && reg_wr_valid && reg_wr_addr == apmc_pkg::ADDR_UNLOCK
        && reg_wr_data == apmc_pkg::DATA_UNLOCK) |=> s_r.unlocked)
        else $error("interface dead in deep sleep");

    chk_deep_ready: assert property ( // R10
        s_r.deep_off |-> s_r.ready && !s_r.conv)
        else $error("ready low in deep sleep");

    chk_deep_exit: assert property ( // R11
        (s_r.deep_off && !deep_req) |=> s_r.ready && !s_r.deep_off
        && s_r.state == apmc_pkg::ST_PWRUP)
        else $error("power-up not started");

endmodule

//--- verification/apmc_host_model.sv
`timescale 1ns/1ps
module apmc_host_model (
    input wire logic core_clk,
    output logic conversion_start,
    output logic chip_select_n,
    output logic reg_wr_valid,
    output logic [apmc_pkg::REG_ADDR_W-1:0] reg_wr_addr,
    output logic [apmc_pkg::REG_DATA_W-1:0] reg_wr_data
);
    // Idle pin levels
    initial begin
        conversion_start = 1'b0;
        chip_select_n = 1'b1;
        reg_wr_valid = 1'b0;
        reg_wr_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    // One-cycle write; bus scrambled afterwards
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr_valid = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = d;
        @(negedge core_clk);
        reg_wr_valid = 1'b0;
        reg_wr_addr = ~a;
        reg_wr_data = ~d;
    endtask
    // Serial frame ends with chip select rising
    task automatic frame();
        @(negedge core_clk);
        chip_select_n = 1'b0;
        repeat (3) @(negedge core_clk);
        chip_select_n = 1'b1;
    endtask
    // Start pin level, then hold off for gap cycles
    task automatic cst(input logic v, input int gap);
        @(negedge core_clk);
        conversion_start = v;
        repeat (gap) @(negedge core_clk);
    endtask
endmodule

//--- verification/adc_power_mode_control_tb.sv
`timescale 1ns/1ps
module adc_power_mode_control_tb;
    localparam int CC = 4;
    localparam int WC = 3;
    localparam int PC = 5;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cst, csn, wv, rdy, conv, nap, deep;
    logic [7:0] wa, wd, pdc;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    logic [7:0] m_pdc = 8'h00;
    bit m_unl = 0;

    // Core clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    apmc_power_ctrl #(.CONV_CYC(CC), .NAP_WAKE_CYC(WC), .PWRUP_CYC(PC)) dut (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .conversion_start(cst), .chip_select_n(csn),
        .reg_wr_valid(wv), .reg_wr_addr(wa), .reg_wr_data(wd),
        .ready_output(rdy), .converting(conv), .nap_power_down(nap),
        .deep_sleep_mode(deep), .power_down_control(pdc));
    apmc_host_model host (
        .core_clk(core_clk), .conversion_start(cst), .chip_select_n(csn),
        .reg_wr_valid(wv), .reg_wr_addr(wa), .reg_wr_data(wd));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write through the host and update the reference model
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == 8'h04 && m_unl) m_pdc = d;
        if (a == 8'h04) m_unl = 0;
        if (a == 8'h11 && d == 8'h69) m_unl = 1;
        @(negedge core_clk);
        chk(pdc, m_pdc);
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: return conv;
            1: return nap;
            2: return deep;
            default: return rdy;
        endcase
    endfunction
    // Bounded wait for an output level, cycles in k
    task automatic wt(input int w, input logic v, output int k);
        k = 0;
        while (sel(w) !== v && k < 50) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 50) chk(8'h00, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d bad=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h2c301612));
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk(rdy, 8'h01);
        chk({conv, nap, deep}, 8'h00);
        chk(pdc, 8'h00);
        $display("test reset done");
        host.cst(1, 0);
        wt(0, 1, n);
        chk(rdy, 8'h00);
        wt(0, 0, n);
        chk(n, CC);
        repeat (3) @(negedge core_clk);
        chk(nap, 8'h00);
        chk(rdy, 8'h01);
        $display("test plain conversion done");
        wr(8'h04, 8'h01);
        wr(8'h20 + 8'($urandom % 16), 8'($urandom));
        wr(8'h11, 8'h68);
        wr(8'h11, 8'h69);
        wr(8'h04, 8'h01);
        $display("test unlock done");
        host.cst(0, WC + 4);
        host.cst(1, 0);
        wt(0, 1, n);
        wt(0, 0, n);
        chk(n, CC);
        @(negedge core_clk);
        chk(nap, 8'h01);
        chk(rdy, 8'h01);
        repeat (5 + $urandom % 16) @(negedge core_clk);
        chk(nap, 8'h01);
        // Clock enable low freezes the sequencer and its synchroniser
        ce = 1'b0;
        host.cst(0, 6);
        chk(nap, 8'h01);
        chk(rdy, 8'h01);
        ce = 1'b1;
        host.cst(0, 0);
        wt(1, 0, n);
        chk(rdy, 8'h00);
        wt(3, 1, n);
        chk(n, WC);
        $display("test light sleep done");
        wr(8'h11, 8'h69);
        wr(8'h04, 8'h02);
        chk(deep, 8'h00);
        host.frame();
        wt(2, 1, n);
        chk(rdy, 8'h01);
        host.cst(1, 8);
        chk(conv, 8'h00);
        chk(pdc, 8'h02);
        host.cst(0, 4);
        $display("test deep sleep done");
        wr(8'h11, 8'h69);
        wr(8'h04, 8'h00);
        wt(2, 0, n);
        chk(rdy, 8'h01);
        host.cst(0, PC + 4);
        host.cst(1, 0);
        wt(0, 1, n);
        chk(n < 8, 8'h01);
        $display("test power up done");
        report_and_stop();
    end
endmodule
